// [logic/xcvr_ctrl.sv]
// Purpose: Serial register port and operating-mode decode
// Assumes: Serial pins are synchronous to clock_i and slower than it
// Notes:   Power-group enables and clock/bias outputs are registered
//
// Functional notes
// R1: 16-bit frame: rw, 5 address, 10 data
// R2: 32 registers of 10 bits each
// R3: MSB first, framed by chip select low
// R4: Sample data in on serial clock rise
// R5: Read data driven on serial clock fall
// R6: Chip select rise writes received data
// R7: Registers keep contents through shutdown
// R8: Registers return to defaults at power-up
// R9: Both pins low: everything off
// R10: Mode bit0 low: clock output only
// R11: Enable low, select high, 01: standby
// R12: Receive; pair bit picks A or both
// R13: Receiver B never powered alone
// R14: Transmit powers transmit path and synthesizer
// R15: Amplifier bias after programmable delay
// R16: Transmit calibration with detector routing
// R17: Loopback calibration, LNAs and driver off
// R18: Loopback bypasses transmit lowpass filters
// R19: Groups individually powered down by register
// R20: Unlisted combinations decode as standby
`timescale 1ns/1ps
module xcvr_ctrl
  import xcvr_ctrl_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic cs_n_i,
  input  wire logic sclk_i,
  input  wire logic din_i,
  output logic      dout_o,
  input  wire logic enable_i,
  input  wire logic tx_rx_select_pin_i,
  output power_t    power_o,
  output logic      ref_clock_output_o,
  output logic      ext_amp_bias_output_o,
  output op_mode_t  mode_o
);

  // ----------------------------------------------------------------
  // Serial port state
  // ----------------------------------------------------------------
  logic [DATA_BITS-1:0]  regs_q [REG_COUNT];
  logic [DATA_BITS-1:0]  regs_d [REG_COUNT];
  logic [FRAME_BITS-1:0] shift_q, shift_d;
  logic [CNT_W-1:0]      cnt_q, cnt_d;
  logic [ADDR_BITS-1:0]  addr_q, addr_d;
  logic                  rw_q, rw_d;
  logic                  sclk_q, cs_n_q;
  logic                  dout_q, dout_d;
  logic                  sclk_rise, sclk_fall, cs_rise;
  logic [3:0]            rd_idx;

  // Pins are sampled, so a level shorter than one clock can be lost
  assign sclk_rise = sclk_i & ~sclk_q;
  assign sclk_fall = ~sclk_i & sclk_q;
  assign cs_rise   = cs_n_i & ~cs_n_q;
  assign rd_idx    = 4'(CNT_TOP_IDX - cnt_q);

  always_comb begin
    shift_d = shift_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    rw_d    = rw_q;
    dout_d  = dout_q;
    if (cs_n_i) begin
      cnt_d = '0;
    end else begin
      // R3: shift in MSB first
      // R4: sample on rising edge
      if (sclk_rise && cnt_q != CNT_FULL) begin
        shift_d = {shift_q[FRAME_BITS-2:0], din_i};
        cnt_d   = cnt_q + 5'h01;
        // R1: top bit is read/write
        if (cnt_q == '0) begin
          rw_d = din_i;
        end
        // R1: next five bits address
        if (cnt_q == CNT_ADDR_LAST - CNT_RW_DONE + CNT_RW_DONE) begin
          addr_d = {shift_q[ADDR_BITS-2:0], din_i};
        end
      end
      // R5: read data on falling edge
      if (sclk_fall && rw_q == RW_READ && cnt_q >= CNT_ADDR_DONE
          && cnt_q != CNT_FULL) begin
        dout_d = regs_q[addr_q][rd_idx];
      end
    end
    if (cs_n_i) begin
      dout_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      shift_q <= '0;
      cnt_q   <= '0;
      addr_q  <= '0;
      rw_q    <= 1'b0;
      dout_q  <= 1'b0;
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
    end else begin
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      rw_q    <= rw_d;
      dout_q  <= dout_d;
      sclk_q  <= sclk_i;
      cs_n_q  <= cs_n_i;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Commit waits for chip select rise, so a cut frame never lands
  always_comb begin
    regs_d = regs_q;
    // R6: latch data on chip select rise
    if (cs_rise && cnt_q == CNT_FULL && rw_q != RW_READ) begin
      regs_d[addr_q] = shift_q[DATA_BITS-1:0];
    end
  end

  // R8: defaults at reset
  // R7: no mode term clears the registers
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= REG_DEFAULT;
      end
    end else begin
      regs_q <= regs_d;
    end
  end

  // R5: data out stays low over the six rw and address bits of a read
  assign dout_o = dout_q;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  op_mode_t mode_q, mode_d;
  logic [1:0] op_field;
  logic       pair_sel;
  logic [DATA_BITS-1:0] pwr_mask;

  assign op_field = regs_q[REG_OP_MODE][OP_MODE_LSB +: 2];
  assign pair_sel = regs_q[REG_RX_PAIR][RX_PAIR_BIT];
  assign pwr_mask = regs_q[REG_PWR_MASK];

  always_comb begin
    mode_d = MODE_STANDBY;
    // R9: both pins low is shutdown
    if (!enable_i && !tx_rx_select_pin_i) begin
      mode_d = MODE_SHUTDOWN;
    // R10: bit 0 clear keeps clock only
    end else if (!op_field[0]) begin
      mode_d = MODE_REF_CLOCK_OUTPUT;
    end else if (op_field == OP_MODE_NORMAL) begin
      case ({enable_i, tx_rx_select_pin_i})
        // R11: standby decode
        2'h1: mode_d = MODE_STANDBY;
        // R12: receive decode
        2'h3: mode_d = MODE_RX;
        // R14: transmit decode
        2'h2: mode_d = MODE_TX;
        default: mode_d = MODE_STANDBY;
      endcase
    end else begin
      case ({enable_i, tx_rx_select_pin_i})
        // R16: transmit calibration decode
        2'h2: mode_d = MODE_TX_CAL;
        // R17: loopback decode
        2'h3: mode_d = MODE_RX_CAL;
        // R20: leftovers fall to standby
        default: mode_d = MODE_STANDBY;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power group enables
  // ----------------------------------------------------------------
  power_t pwr_q, pwr_d;
  logic   refclk_q, refclk_d;
  logic   synth_ok, rx_ok, tx_ok, drv_ok, cal_ok;

  // R19: per-group power-down bits
  assign synth_ok = ~pwr_mask[MASK_SYNTH];
  assign rx_ok    = ~pwr_mask[MASK_RX];
  assign tx_ok    = ~pwr_mask[MASK_TX];
  assign drv_ok   = ~pwr_mask[MASK_PA_DRV];
  assign cal_ok   = ~pwr_mask[MASK_CAL];

  always_comb begin
    pwr_d    = '0;
    refclk_d = 1'b1;
    case (mode_d)
      MODE_SHUTDOWN: refclk_d = 1'b0;
      // Divider must run to feed the clock output
      MODE_REF_CLOCK_OUTPUT: pwr_d.clk_div = 1'b1;
      MODE_STANDBY: begin
        pwr_d.clk_div = 1'b1;
        pwr_d.synth   = synth_ok;
      end
      MODE_RX: begin
        // R13: B only ever joins A
        pwr_d.rx_a    = rx_ok;
        pwr_d.rx_b    = rx_ok & pair_sel;
        pwr_d.lna     = rx_ok;
        pwr_d.synth   = synth_ok;
        pwr_d.clk_div = 1'b1;
      end
      MODE_TX: begin
        pwr_d.tx_path   = tx_ok;
        pwr_d.pa_driver = tx_ok & drv_ok;
        pwr_d.synth     = synth_ok;
        pwr_d.clk_div   = 1'b1;
      end
      MODE_TX_CAL: begin
        // R16: driver off, detector routed
        pwr_d.tx_path       = tx_ok;
        pwr_d.am_detector   = cal_ok;
        pwr_d.rx_iq_buffer  = cal_ok;
        pwr_d.det_to_iq_mux = cal_ok;
        pwr_d.synth         = synth_ok;
        pwr_d.clk_div       = 1'b1;
      end
      MODE_RX_CAL: begin
        // R17: loopback, no LNA or driver
        pwr_d.rx_a          = rx_ok;
        pwr_d.rx_b          = rx_ok & pair_sel;
        pwr_d.tx_path       = tx_ok;
        pwr_d.loopback      = cal_ok;
        // R18: bypass transmit lowpass
        pwr_d.tx_lpf_bypass = 1'b1;
        pwr_d.synth         = synth_ok;
        pwr_d.clk_div       = 1'b1;
      end
      default: refclk_d = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      mode_q   <= MODE_SHUTDOWN;
      pwr_q    <= '0;
      refclk_q <= 1'b0;
    end else begin
      mode_q   <= mode_d;
      pwr_q    <= pwr_d;
      refclk_q <= refclk_d;
    end
  end

  assign power_o            = pwr_q;
  assign ref_clock_output_o = refclk_q;
  assign mode_o             = mode_q;

  // ----------------------------------------------------------------
  // Amplifier bias delay
  // ----------------------------------------------------------------
  logic [PA_CNT_W-1:0] pa_cnt_q, pa_cnt_d;
  logic [PA_CNT_W-1:0] pa_limit;
  logic                bias_q, bias_d;

  // Product fits: 10-bit field times a small step count
  assign pa_limit = PA_CNT_W'(regs_q[REG_PA_DELAY])
                    * PA_CNT_W'(PA_STEP_CYC);

  // Count restarts each time transmit or the driver drops
  always_comb begin
    pa_cnt_d = '0;
    bias_d   = 1'b0;
    // R15: bias only after delay
    if (mode_q == MODE_TX && pwr_q.pa_driver) begin
      if (pa_cnt_q >= pa_limit) begin
        pa_cnt_d = pa_cnt_q;
        bias_d   = 1'b1;
      end else begin
        pa_cnt_d = pa_cnt_q + 14'h0001;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      pa_cnt_q <= '0;
      bias_q   <= 1'b0;
    end else begin
      pa_cnt_q <= pa_cnt_d;
      bias_q   <= bias_d;
    end
  end

  assign ext_amp_bias_output_o = bias_q;

endmodule : xcvr_ctrl

// [logic/xcvr_ctrl_pkg.sv]
// Purpose: Shared constants and types for the transceiver control block
// Assumes: 20 MHz system clock, serial pins synchronous to it
// Notes:   Register offsets and field positions used by the core
package xcvr_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int PA_STEP_NS      = 500;
  localparam int PA_STEP_CYC     = (PA_STEP_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS      = 16;
  localparam int ADDR_BITS       = 5;
  localparam int DATA_BITS       = 10;
  localparam int REG_COUNT       = 32;
  localparam int CNT_W           = 5;
  localparam logic [CNT_W-1:0] CNT_RW_DONE   = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ADDR_LAST = 5'h05;
  localparam logic [CNT_W-1:0] CNT_ADDR_DONE = 5'h06;
  localparam logic [CNT_W-1:0] CNT_FULL      = 5'h10;
  localparam logic [CNT_W-1:0] CNT_TOP_IDX   = 5'h0f;
  localparam logic              RW_READ       = 1'b1;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_BITS-1:0] REG_RX_PAIR   = 5'h01;
  localparam logic [ADDR_BITS-1:0] REG_PWR_MASK  = 5'h0f;
  localparam logic [ADDR_BITS-1:0] REG_OP_MODE   = 5'h10;
  localparam logic [ADDR_BITS-1:0] REG_PA_DELAY  = 5'h11;
  localparam int RX_PAIR_BIT     = 3;
  localparam int OP_MODE_LSB     = 0;
  localparam logic [1:0] OP_MODE_NORMAL = 2'h1;
  localparam logic [1:0] OP_MODE_CAL    = 2'h3;
  localparam logic [DATA_BITS-1:0] REG_DEFAULT = 10'h000;
  localparam int PA_CNT_W        = 14;

  // Power-down mask bit positions
  localparam int MASK_SYNTH      = 0;
  localparam int MASK_RX         = 1;
  localparam int MASK_TX         = 2;
  localparam int MASK_PA_DRV     = 3;
  localparam int MASK_CAL        = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    MODE_SHUTDOWN = 7'b0000001,
    MODE_REF_CLOCK_OUTPUT   = 7'b0000010,
    MODE_STANDBY  = 7'b0000100,
    MODE_RX       = 7'b0001000,
    MODE_TX       = 7'b0010000,
    MODE_TX_CAL   = 7'b0100000,
    MODE_RX_CAL   = 7'b1000000
  } op_mode_t;

  typedef struct packed {
    logic rx_a;
    logic rx_b;
    logic lna;
    logic tx_path;
    logic pa_driver;
    logic synth;
    logic clk_div;
    logic am_detector;
    logic rx_iq_buffer;
    logic det_to_iq_mux;
    logic loopback;
    logic tx_lpf_bypass;
  } power_t;

endpackage : xcvr_ctrl_pkg

// [verification/spi_host_model.sv]
// Purpose: Serial host that frames transfers into the block
// Assumes: Clock high 2 cycles, low 3 cycles
// Notes:   Short frames allowed so refusal can be tested
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clock_i,
  input  wire logic dout_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      din_o
);
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  task automatic wt(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : wt
  task automatic xfer(input logic [15:0] f, input int n,
                      output logic [9:0] rd);
    rd = '0;
    cs_n_o = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      din_o = f[i];
      sclk_o = 1'b0;
      wt(3);
      if (i < 10) rd[i] = dout_i;
      sclk_o = 1'b1;
      wt(2);
    end
    sclk_o = 1'b0;
    wt(3);
    cs_n_o = 1'b1;
    // Released line must not keep the last bit
    din_o = ~din_o;
    wt(3);
  endtask : xfer
endmodule : spi_host_model

// [verification/transceiver_serial_ctrl_and_mode_decode_bench.sv]
// Purpose: Self-checking bench for the transceiver control block
// Assumes: 50 ns clock, host model drives the serial pins
// Notes:   Full pin and field table swept
`timescale 1ns/1ps
module transceiver_serial_ctrl_and_mode_decode_bench;
  import xcvr_ctrl_pkg::*;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  logic       clock_i = 1'b0;
  logic       nrst_i;
  logic       en;
  logic       sel;
  logic       cs_n, sclk, din, dout, refclk, bias;
  power_t     pwr;
  op_mode_t   mode;
  logic [9:0] regs [32];
  logic [9:0] rd;
  logic [4:0] a;
  int         mismatches = 0;
  int         num_checks = 0;
  int         cycles = 0;
  always #25 clock_i = ~clock_i;
  xcvr_ctrl dut (.clock_i, .nrst_i, .cs_n_i(cs_n), .sclk_i(sclk),
    .din_i(din), .dout_o(dout), .enable_i(en),
    .tx_rx_select_pin_i(sel), .power_o(pwr), .ref_clock_output_o(refclk),
    .ext_amp_bias_output_o(bias), .mode_o(mode));
  spi_host_model u_host (.clock_i, .dout_i(dout), .cs_n_o(cs_n),
    .sclk_o(sclk), .din_o(din));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic wr(input logic [4:0] ad, input logic [9:0] d);
    u_host.xfer({1'b0, ad, d}, 16, rd);
    regs[ad] = d;
  endtask : wr
  task automatic rdchk(input logic [4:0] ad);
    u_host.xfer({1'b1, ad, 10'h000}, 16, rd);
    check(rd, regs[ad]);
  endtask : rdchk
  function automatic op_mode_t em(logic e, logic s, logic [1:0] f);
    if (!e && !s) return MODE_SHUTDOWN;
    if (!f[0]) return MODE_REF_CLOCK_OUTPUT;
    if (f[1]) return (e && s) ? MODE_RX_CAL : (e ? MODE_TX_CAL : MODE_STANDBY);
    return (e && s) ? MODE_RX : (e ? MODE_TX : MODE_STANDBY);
  endfunction : em
  task automatic mode_chk(input logic e, s, p, input logic [1:0] f);
    op_mode_t m;
    wr(REG_RX_PAIR, {6'h00, p, 3'h0});
    wr(REG_OP_MODE, {8'h00, f});
    en = e;
    sel = s;
    u_host.wt(3);
    m = em(e, s, f);
    check(mode, m);
    check(pwr.rx_b, (m == MODE_RX || m == MODE_RX_CAL) && p);
    check(refclk, e | s);
    check(pwr.pa_driver, m == MODE_TX);
    check(pwr.lna, m == MODE_RX);
    check(pwr.loopback, m == MODE_RX_CAL);
    check(pwr.tx_lpf_bypass, m == MODE_RX_CAL);
    check(pwr.am_detector, m == MODE_TX_CAL);
    check(pwr.rx_a, m == MODE_RX || m == MODE_RX_CAL);
  endtask : mode_chk
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    nrst_i = 1'b0;
    en = 1'b0;
    sel = 1'b0;
    void'($urandom(1));
    foreach (regs[i]) regs[i] = REG_DEFAULT;
    u_host.wt(12);
    nrst_i = 1'b1;
    u_host.wt(2);
    check(pwr, '0);
    check(mode, MODE_SHUTDOWN);
    check(refclk, 1'b0);
    check(bias, 1'b0);
    check(dout, 1'b0);
    $display("test reset done");
    // Written in shutdown, so retention is covered as well
    for (int i = 0; i < 8; i++) begin
      a = 5'($urandom_range(31));
      wr(a, 10'($urandom));
    end
    for (int i = 0; i < 32; i++) rdchk(5'(i));
    $display("test registers done");
    u_host.xfer({1'b0, 5'h02, ~regs[2]}, 15, rd);
    u_host.xfer({1'b1, 5'h03, ~regs[3]}, 16, rd);
    rdchk(5'h02);
    rdchk(5'h03);
    $display("test refused frames done");
    wr(REG_PWR_MASK, 10'h000);
    for (int k = 0; k < 32; k++) mode_chk(k[4], k[3], k[2], k[1:0]);
    $display("test mode table done");
    wr(REG_OP_MODE, 10'h001);
    wr(REG_PWR_MASK, 10'h002);
    en = 1'b1;
    sel = 1'b1;
    u_host.wt(3);
    check(pwr.rx_a, 1'b0);
    wr(REG_PWR_MASK, 10'h000);
    u_host.wt(3);
    check(pwr.rx_a, 1'b1);
    wr(REG_OP_MODE, 10'h003);
    wr(REG_PWR_MASK, 10'h010);
    u_host.wt(3);
    check(pwr.loopback, 1'b0);
    check(pwr.rx_a, 1'b1);
    wr(REG_PWR_MASK, 10'h000);
    wr(REG_OP_MODE, 10'h001);
    $display("test masking done");
    wr(REG_PA_DELAY, 10'h003);
    sel = 1'b0;
    u_host.wt(3 * PA_STEP_CYC - 10);
    check(bias, 1'b0);
    u_host.wt(20);
    check(bias, 1'b1);
    en = 1'b0;
    u_host.wt(3);
    check(bias, 1'b0);
    $display("test amp bias done");
    en = 1'b1;
    nrst_i = 1'b0;
    u_host.wt(2);
    nrst_i = 1'b1;
    u_host.wt(2);
    check(mode, MODE_REF_CLOCK_OUTPUT);
    check(bias, 1'b0);
    foreach (regs[i]) regs[i] = REG_DEFAULT;
    rdchk(REG_PA_DELAY);
    rdchk(REG_OP_MODE);
    $display("test second reset done");
    stop_test();
  end
endmodule : transceiver_serial_ctrl_and_mode_decode_bench

// [verification/xcvr_ctrl_properties.sv]
// Purpose: Port checks for the transceiver control block
// Assumes: Host holds serial clock low for 3 cycles
// Notes:   Bound into every instance of the block
`timescale 1ns/1ps
module xcvr_ctrl_properties
  import xcvr_ctrl_pkg::*;
(
  input wire logic     clock_i,
  input wire logic     nrst_i,
  input wire logic     cs_n_i,
  input wire logic     sclk_i,
  input wire logic     dout_o,
  input wire logic     enable_i,
  input wire logic     tx_rx_select_pin_i,
  input wire power_t   power_o,
  input wire logic     ref_clock_output_o,
  input wire logic     ext_amp_bias_output_o,
  input wire op_mode_t mode_o
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  a_shutdown_all_off:
    assert property (!enable_i && !tx_rx_select_pin_i |=> power_o == '0
      && mode_o == MODE_SHUTDOWN && !ref_clock_output_o)
    else $error("power left on with both pins low");
  a_clock_out_on:
    assert property (enable_i || tx_rx_select_pin_i |=> ref_clock_output_o)
    else $error("clock output off while active");
  a_sel_only_mode:
    assert property (!enable_i && tx_rx_select_pin_i
      |=> mode_o inside {MODE_REF_CLOCK_OUTPUT, MODE_STANDBY})
    else $error("bad mode with enable low, select high");
  a_rx_b_paired:
    assert property (power_o.rx_b |-> power_o.rx_a)
    else $error("receiver B powered alone");
  a_tx_rx_off:
    assert property (mode_o == MODE_TX |-> !power_o.rx_a && !power_o.lna)
    else $error("receive path on in transmit");
  a_txcal_no_drv:
    assert property (mode_o == MODE_TX_CAL |-> !power_o.pa_driver
      && !power_o.lna && !power_o.rx_a)
    else $error("driver or receiver on in transmit calibration");
  a_loop_no_lna:
    assert property (mode_o == MODE_RX_CAL |-> !power_o.lna
      && !power_o.pa_driver)
    else $error("amplifier on in loopback");
  a_lpf_bypass_only:
    assert property (power_o.tx_lpf_bypass |-> mode_o == MODE_RX_CAL)
    else $error("filter bypass outside loopback");
  a_bias_tx_only:
    assert property (ext_amp_bias_output_o |-> mode_o == MODE_TX
      || $past(mode_o) == MODE_TX)
    else $error("amp bias outside transmit");
  // Falls are seen within 2 cycles, so low must still be showing
  a_dout_on_fall:
    assert property (!cs_n_i && !$past(cs_n_i) && $changed(dout_o)
      |-> !sclk_i)
    else $error("data out moved outside a clock fall");
  a_dout_idle:
    assert property (cs_n_i |=> !dout_o)
    else $error("data out driven while deselected");
endmodule : xcvr_ctrl_properties

bind xcvr_ctrl xcvr_ctrl_properties u_props (.clock_i, .nrst_i, .cs_n_i,
  .sclk_i, .dout_o, .enable_i, .tx_rx_select_pin_i, .power_o,
  .ref_clock_output_o, .ext_amp_bias_output_o, .mode_o);
